/* logic/txqfc_pkg.sv */
// constants for the transmit queue status and fifo control register bank
package txqfc_pkg;
    localparam int NUM_FIFOS = 31;
    // register byte addresses on the serial link
    localparam logic [11:0] TXQ_STA_ADDR  = 12'h000;
    localparam logic [11:0] TXQ_HEAD_ADDR = 12'h004;
    localparam logic [11:0] FCON_BASE     = 12'h080;
    localparam logic [11:0] FCON_STRIDE   = 12'h004;
    // serial frame layout
    localparam logic [3:0] CMD_WRITE  = 4'h2;
    localparam logic [3:0] CMD_READ   = 4'h3;
    localparam logic [5:0] HDR_BITS   = 6'h10;
    localparam logic [5:0] FRAME_BITS = 6'h30;
    // queue status word fields
    localparam int STA_ABT  = 7;
    localparam int STA_ARB  = 6;
    localparam int STA_ERR  = 5;
    localparam int STA_ATIF = 4;
    // fifo control word fields
    localparam int FCON_PL_LSB    = 29;
    localparam int FCON_DEP_LSB   = 24;
    localparam int FCON_RETRY_LSB = 21;
    localparam int FCON_PRI_LSB   = 16;
    localparam int FCON_CLR       = 10;
    localparam int FCON_REQ       = 9;
    localparam int FCON_ADV       = 8;
    localparam int FCON_DIR       = 7;
    localparam int FCON_RTR       = 6;
    localparam int FCON_RXTS      = 5;
    localparam logic [31:0] FCON_CFG_MASK = 32'hFF00_00A0;
    localparam logic [31:0] FCON_RUN_MASK = 32'h007F_005F;
    localparam logic [31:0] FCON_RST      = 32'h0060_0000;
    localparam logic        FCON_CLR_RST  = 1'h1;
    // retry policy codes as seen by the protocol engine
    localparam logic [1:0] RETRY_UNLIMITED = 2'h2;
    // message object header bytes ahead of the payload
    localparam logic [7:0] OBJ_HDR_BYTES = 8'h08;
endpackage

/* logic/txqfc_csr_if.sv */
// register access strobes between the serial slave and the register bank
`timescale 1ns/1ps
`default_nettype none
interface txqfc_csr_if;
    logic        wr_stb;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport spi (output wr_stb, output addr, output wdata, input rdata);
    modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* logic/txqfc_spi_slave.sv */
// serial slave: 4-bit command, 12-bit address, 32-bit word, mode 0
`timescale 1ns/1ps
`default_nettype none
module txqfc_spi_slave
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // serial pins
    input  wire logic spi_sclk,
    input  wire logic spi_cs_n,
    input  wire logic spi_mosi,
    output var  logic spi_miso,
    output var  logic spi_miso_oe_n,
    // register side
    txqfc_csr_if.spi  csr
);
    logic [2:0]  sclk_q;
    logic [1:0]  cs_q;
    logic [1:0]  mosi_q;
    logic [5:0]  cnt;
    logic [31:0] sh_in;
    logic [31:0] sh_out;
    logic [3:0]  cmd;
    logic        load;

    wire        sel      = ~cs_q[1];
    wire        rise     = sclk_q[1] & ~sclk_q[2];
    wire        fall     = ~sclk_q[1] & sclk_q[2];
    wire [31:0] next_in  = {sh_in[30:0], mosi_q[1]};
    wire        hdr_done = rise && sel && (cnt == txqfc_pkg::HDR_BITS - 6'h01);
    wire        frm_done = rise && sel && (cnt == txqfc_pkg::FRAME_BITS - 6'h01);
    wire        shift_out = fall && sel && (cnt >= txqfc_pkg::HDR_BITS);

    // only the second stage and the edge history are read
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sclk_q <= 3'h0;
            cs_q   <= 2'h3;
            mosi_q <= 2'h0;
        end
        else
        begin
            sclk_q <= {sclk_q[1:0], spi_sclk};
            cs_q   <= {cs_q[0], spi_cs_n};
            mosi_q <= {mosi_q[0], spi_mosi};
        end
    end

    // bits beyond one 48-bit frame are ignored until chip select rises
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            cnt <= 6'h00;
        else if (!sel)
            cnt <= 6'h00;
        else if (rise && cnt < txqfc_pkg::FRAME_BITS)
            cnt <= cnt + 6'h01;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sh_in     <= 32'h0000_0000;
            cmd       <= 4'h0;
            csr.addr  <= 12'h000;
            csr.wdata <= 32'h0000_0000;
        end
        else
        begin
            if (rise && sel)
                sh_in <= next_in;
            if (hdr_done)
            begin
                cmd      <= next_in[15:12];
                csr.addr <= next_in[11:0];
            end
            if (frm_done)
                csr.wdata <= next_in;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            csr.wr_stb <= 1'b0;
            load       <= 1'b0;
        end
        else
        begin
            csr.wr_stb <= frm_done && (cmd == txqfc_pkg::CMD_WRITE);
            load       <= hdr_done && (next_in[15:12] == txqfc_pkg::CMD_READ);
        end
    end

    // read data is captured once; the host sees a snapshot, not live flags
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sh_out        <= 32'h0000_0000;
            spi_miso      <= 1'b0;
            spi_miso_oe_n <= 1'b1;
        end
        else
        begin
            spi_miso_oe_n <= ~sel;
            if (load)
                sh_out <= csr.rdata;
            else if (shift_out)
                {spi_miso, sh_out} <= {sh_out, 1'b0};
            else if (!sel)
                spi_miso <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* logic/txqfc_regs.sv */
// transmit queue status, head address and fifo control register bank
`timescale 1ns/1ps
`default_nettype none
module txqfc_regs
#(
    parameter int NUM_FIFOS = txqfc_pkg::NUM_FIFOS
)
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    // serial pins
    input  wire logic                 spi_sclk,
    input  wire logic                 spi_cs_n,
    input  wire logic                 spi_mosi,
    output var  logic                 spi_miso,
    output var  logic                 spi_miso_oe_n,
    // controller mode
    input  wire logic                 config_mode,
    input  wire logic                 global_retry_limit_enable,
    // transmit queue set-up
    input  wire logic [4:0]           txq_depth_code,
    input  wire logic [2:0]           txq_payload_code,
    input  wire logic [31:0]          txq_ram_base,
    // transmit queue events
    input  wire logic                 txq_push,
    input  wire logic                 txq_send_request_set,
    input  wire logic                 txq_msg_end,
    input  wire logic                 txq_end_aborted,
    input  wire logic                 txq_end_arb_lost,
    input  wire logic                 txq_end_bus_error,
    input  wire logic                 txq_attempts_exhausted,
    input  wire logic                 txq_reset,
    // fifo events from the protocol engine
    input  wire logic [NUM_FIFOS-1:0] fifo_all_sent,
    // fifo selected for the engine to inspect
    input  wire logic [4:0]           sel_fifo,
    output var  logic [6:0]           sel_payload_bytes,
    output var  logic [5:0]           sel_depth,
    output var  logic [1:0]           sel_retry_policy,
    output var  logic [4:0]           sel_priority,
    output var  logic                 sel_remote_reply_en,
    output var  logic                 sel_rx_ts_en,
    // per fifo controls
    output var  logic [NUM_FIFOS-1:0] fifo_send_request,
    output var  logic [NUM_FIFOS-1:0] fifo_is_tx,
    output var  logic [NUM_FIFOS-1:0] fifo_reset_pulse,
    output var  logic [NUM_FIFOS-1:0] fifo_abort_req,
    output var  logic [NUM_FIFOS-1:0] fifo_advance
);
    txqfc_csr_if csr ();

    txqfc_spi_slave u_spi
    (
        .ref_clk       (ref_clk),
        .nrst          (nrst),
        .spi_sclk      (spi_sclk),
        .spi_cs_n      (spi_cs_n),
        .spi_mosi      (spi_mosi),
        .spi_miso      (spi_miso),
        .spi_miso_oe_n (spi_miso_oe_n),
        .csr           (csr.spi)
    );

    function automatic logic [6:0] payload_bytes(input logic [2:0] code);
        case (code)
            3'h0:    payload_bytes = 7'h08;
            3'h1:    payload_bytes = 7'h0C;
            3'h2:    payload_bytes = 7'h10;
            3'h3:    payload_bytes = 7'h14;
            3'h4:    payload_bytes = 7'h18;
            3'h5:    payload_bytes = 7'h20;
            3'h6:    payload_bytes = 7'h30;
            default: payload_bytes = 7'h40;
        endcase
    endfunction

    // returns fifo number 1..31 for an aligned control address, else zero
    function automatic logic [5:0] fcon_sel(input logic [11:0] a);
        logic [11:0] off;
        off = a - txqfc_pkg::FCON_BASE;
        fcon_sel = 6'h00;
        if (a > txqfc_pkg::FCON_BASE && off[1:0] == 2'h0
            && off <= 12'(NUM_FIFOS) * txqfc_pkg::FCON_STRIDE)
            fcon_sel = off[7:2];
    endfunction

    // ---- transmit queue occupancy
    logic [4:0] send_idx;
    logic [4:0] head_idx;
    logic [5:0] q_count;
    logic       flag_abt;
    logic       flag_arb;
    logic       flag_err;
    logic       flag_atif;

    wire [5:0] q_depth  = {1'b0, txq_depth_code} + 6'h01;
    wire       q_empty  = q_count == 6'h00;
    wire       q_full   = q_count >= q_depth;
    wire       do_push  = txq_push && !q_full;
    wire       do_pop   = txq_msg_end && !q_empty;
    wire [4:0] next_send_idx = (send_idx >= txq_depth_code) ? 5'h00 : send_idx + 5'h01;
    wire [4:0] next_head_idx = (head_idx >= txq_depth_code) ? 5'h00 : head_idx + 5'h01;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            send_idx <= 5'h00;
            head_idx <= 5'h00;
            q_count  <= 6'h00;
        end
        else if (txq_reset)
        begin
            send_idx <= 5'h00;
            head_idx <= 5'h00;
            q_count  <= 6'h00;
        end
        else
        begin
            if (do_pop)
                send_idx <= next_send_idx;
            if (do_push)
                head_idx <= next_head_idx;
            q_count <= q_count + {5'h00, do_push} - {5'h00, do_pop};
        end
    end

    // ---- queue status flags; a message end (for atif, an exhausted attempt) in the clearing cycle wins
    wire wr_sta   = csr.wr_stb && csr.addr == txqfc_pkg::TXQ_STA_ADDR;
    wire clr_any  = txq_send_request_set || txq_reset;
    wire clr_abt  = clr_any || (wr_sta && !csr.wdata[txqfc_pkg::STA_ABT]);
    wire clr_arb  = clr_any || (wr_sta && !csr.wdata[txqfc_pkg::STA_ARB]);
    wire clr_err  = clr_any || (wr_sta && !csr.wdata[txqfc_pkg::STA_ERR]);
    wire clr_atif = clr_any || (wr_sta && !csr.wdata[txqfc_pkg::STA_ATIF]);

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            flag_abt <= 1'b0;
            flag_arb <= 1'b0;
            flag_err <= 1'b0;
        end
        else if (txq_msg_end)
        begin
            flag_abt <= txq_end_aborted;
            flag_arb <= txq_end_arb_lost;
            flag_err <= txq_end_bus_error;
        end
        else
        begin
            flag_abt <= flag_abt && !clr_abt;
            flag_arb <= flag_arb && !clr_arb;
            flag_err <= flag_err && !clr_err;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            flag_atif <= 1'b0;
        else
            flag_atif <= txq_attempts_exhausted || (flag_atif && !clr_atif);
    end

    wire [31:0] sta_word = {19'h0, send_idx,
                            flag_abt, flag_arb, flag_err, flag_atif,
                            1'b0, q_empty, 1'b0, !q_full};

    // undefined while configuration rewrites the queue set-up
    wire [7:0]  obj_bytes = txqfc_pkg::OBJ_HDR_BYTES + {1'b0, payload_bytes(txq_payload_code)};
    wire [31:0] head_addr = txq_ram_base + 32'(head_idx) * 32'(obj_bytes);

    // ---- fifo control registers
    logic [31:0]          fcon [NUM_FIFOS];
    logic [31:0]          rd_word [NUM_FIFOS];
    logic [NUM_FIFOS-1:0] fclr;

    wire [5:0] wsel = csr.wr_stb ? fcon_sel(csr.addr) : 6'h00;
    wire [5:0] rsel = fcon_sel(csr.addr);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FIFOS; gi++)
        begin : g_fifo
            wire        hit     = wsel == 6'(gi + 1);
            wire        is_tx   = fcon[gi][txqfc_pkg::FCON_DIR];
            wire        reset_now = fclr[gi] && !config_mode;
            wire        set_req = hit && is_tx && csr.wdata[txqfc_pkg::FCON_REQ];
            wire        abt_req = hit && fifo_send_request[gi]
                                  && !csr.wdata[txqfc_pkg::FCON_REQ];
            wire        hw_clr  = fifo_all_sent[gi] || fclr[gi];
            wire [31:0] cfg_src = config_mode ? csr.wdata : fcon[gi];
            wire [31:0] next_fcon = hit ? (cfg_src & txqfc_pkg::FCON_CFG_MASK)
                                          | (csr.wdata & txqfc_pkg::FCON_RUN_MASK)
                                        : fcon[gi];
            wire        next_req = set_req
                                   || (fifo_send_request[gi] && !hw_clr && !abt_req);
            wire        next_clr = config_mode
                                   || (hit && csr.wdata[txqfc_pkg::FCON_CLR]);

            always_ff @(posedge ref_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    fcon[gi]              <= txqfc_pkg::FCON_RST;
                    fclr[gi]              <= txqfc_pkg::FCON_CLR_RST;
                    fifo_send_request[gi] <= 1'b0;
                end
                else
                begin
                    fcon[gi]              <= next_fcon;
                    fclr[gi]              <= next_clr;
                    fifo_send_request[gi] <= next_req;
                end
            end

            // abort and advance follow the write by one cycle; the reset pulse follows the clear bit by one cycle, two after a write
            always_ff @(posedge ref_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    fifo_reset_pulse[gi] <= 1'b0;
                    fifo_abort_req[gi]   <= 1'b0;
                    fifo_advance[gi]     <= 1'b0;
                end
                else
                begin
                    fifo_reset_pulse[gi] <= reset_now;
                    fifo_abort_req[gi]   <= abt_req;
                    fifo_advance[gi]     <= hit && csr.wdata[txqfc_pkg::FCON_ADV];
                end
            end

            assign fifo_is_tx[gi] = is_tx;
            assign rd_word[gi]    = fcon[gi]
                                    | (32'(fclr[gi]) << txqfc_pkg::FCON_CLR)
                                    | (32'(fifo_send_request[gi]) << txqfc_pkg::FCON_REQ);
        end
    endgenerate

    // ---- read path; unmapped addresses read zero
    wire [4:0]  rd_slot = 5'(rsel - 6'h01);
    assign csr.rdata = (csr.addr == txqfc_pkg::TXQ_STA_ADDR)  ? sta_word
                     : (csr.addr == txqfc_pkg::TXQ_HEAD_ADDR) ? head_addr
                     : (rsel != 6'h00)                        ? rd_word[rd_slot]
                     : 32'h0000_0000;

    // ---- selected fifo view for the protocol engine
    wire        sel_ok   = sel_fifo != 5'h00 && 32'(sel_fifo) <= NUM_FIFOS;
    wire [4:0]  sel_slot = sel_fifo - 5'h01;
    wire [31:0] sel_word = sel_ok ? fcon[sel_slot] : 32'h0000_0000;
    wire [1:0]  sel_code = sel_word[txqfc_pkg::FCON_RETRY_LSB +: 2];
    wire [1:0]  eff_retry = sel_code[1] ? txqfc_pkg::RETRY_UNLIMITED : sel_code;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sel_payload_bytes   <= 7'h00;
            sel_depth           <= 6'h00;
            sel_retry_policy    <= 2'h0;
            sel_priority        <= 5'h00;
            sel_remote_reply_en <= 1'b0;
            sel_rx_ts_en        <= 1'b0;
        end
        else
        begin
            sel_payload_bytes <= payload_bytes(sel_word[txqfc_pkg::FCON_PL_LSB +: 3]);
            sel_depth         <= {1'b0, sel_word[txqfc_pkg::FCON_DEP_LSB +: 5]} + 6'h01;
            // without the global limit the engine retries without bound
            sel_retry_policy  <= global_retry_limit_enable ? eff_retry
                                                           : txqfc_pkg::RETRY_UNLIMITED;
            sel_priority      <= sel_word[txqfc_pkg::FCON_PRI_LSB +: 5];
            sel_remote_reply_en <= sel_word[txqfc_pkg::FCON_RTR];
            sel_rx_ts_en      <= sel_word[txqfc_pkg::FCON_RXTS];
        end
    end

    // ---- checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    index_range_a: assert property (send_idx <= txq_depth_code || $changed(txq_depth_code))
        else $error("queue slot index beyond depth");

    abort_refresh_a: assert property (txq_msg_end |=> flag_abt == $past(txq_end_aborted))
        else $error("abort flag not refreshed at message end");

    arb_refresh_a: assert property (txq_msg_end ##1 1 |-> sta_word[6] == $past(txq_end_arb_lost))
        else $error("arbitration flag not refreshed");

    error_refresh_a: assert property (txq_msg_end |=> csr.rdata[5] == $past(txq_end_bus_error)
                                      || csr.addr != txqfc_pkg::TXQ_STA_ADDR)
        else $error("bus error flag not refreshed");

    flag_clear_a: assert property ((txq_send_request_set && !txq_msg_end) |=>
                                   !flag_abt && !flag_arb && !flag_err)
        else $error("status flags survive send request");

    exhaust_set_a: assert property (txq_attempts_exhausted |=> flag_atif [*1])
        else $error("attempts exhausted flag not set");

    queue_reset_a: assert property ((txq_reset && !txq_msg_end) |=>
                                    q_empty && !q_full && !flag_abt)
        else $error("queue reset left occupancy or flags");

    cfg_lock_a: assert property ((!config_mode && !$past(config_mode)) |->
                                 $stable(fcon[0] & txqfc_pkg::FCON_CFG_MASK))
        else $error("configuration field changed outside configuration");

    clr_auto_a: assert property ((fclr[0] && !config_mode && wsel != 6'h01) |=>
                                 !fclr[0] ##0 fifo_reset_pulse[0])
        else $error("fifo clear bit did not self-clear");

    retry_gate_a: assert property (!global_retry_limit_enable |=>
                                   sel_retry_policy == txqfc_pkg::RETRY_UNLIMITED)
        else $error("retry policy applied without global limit");
endmodule
`default_nettype wire

/* bench/txqfc_host.sv */
// serial host model: one 48-bit frame per chip-select period
`timescale 1ns/1ps
`default_nettype none
module txqfc_host
(
    // clock
    input  wire logic ref_clk,
    // serial pins
    output var  logic sclk,
    output var  logic cs_n,
    output var  logic mosi,
    input  wire logic miso
);
    initial
    begin
        sclk = 1'h0;
        cs_n = 1'h1;
        mosi = 1'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // miso is taken just before each fall, well after its sync delay
    task automatic xfer(input logic [47:0] f, output logic [31:0] d);
        cs_n = 1'h0;
        for (int i = 0; i < 48; i++)
        begin
            mosi = f[47-i];
            tick(4);
            sclk = 1'h1;
            tick(4);
            d = {d[30:0], miso};
            sclk = 1'h0;
        end
        tick(4);
        cs_n = 1'h1;
        // a released line must not keep showing the last bit
        mosi = ~mosi;
        tick(8);
    endtask
endmodule
`default_nettype wire

/* bench/txqfc_regs_bench.sv */
// self-checking bench for the queue status and fifo control register bank
`timescale 1ns/1ps
`default_nettype none
module txqfc_regs_bench;
    logic        ref_clk = 1'h0;
    logic        nrst = 1'h0;
    logic        cfg, gen, push, sreq, mend, ab, arb, berr, ex, qrst, sclk, cs_n, mosi, miso;
    logic [4:0]  dep, sel, prio;
    logic [2:0]  pl;
    logic [30:0] sent, req, istx, rp, ap, vp;
    logic        rr, ts, oe;
    logic [31:0] base, rd, w, v;
    logic [31:0] wv [8];
    logic [6:0]  pbytes;
    logic [5:0]  depth;
    logic [1:0]  retry;
    int          n_errors = 0, checks = 0, cyc = 0, hd = 0, tl = 0, cnt = 0, flg = 0, exf = 0;
    int          nr = 0, na = 0, nv = 0, nl = 0;
    int          bytes [8] = '{8, 12, 16, 20, 24, 32, 48, 64};
    always #4 ref_clk = ~ref_clk;
    txqfc_host h (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    txqfc_regs uut
    (
        .ref_clk(ref_clk), .nrst(nrst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe_n(oe), .config_mode(cfg), .global_retry_limit_enable(gen),
        .txq_depth_code(dep), .txq_payload_code(pl), .txq_ram_base(base), .txq_push(push),
        .txq_send_request_set(sreq), .txq_msg_end(mend), .txq_end_aborted(ab),
        .txq_end_arb_lost(arb), .txq_end_bus_error(berr), .txq_attempts_exhausted(ex),
        .txq_reset(qrst), .fifo_all_sent(sent), .sel_fifo(sel), .sel_payload_bytes(pbytes),
        .sel_depth(depth), .sel_retry_policy(retry), .sel_priority(prio),
        .sel_remote_reply_en(rr), .sel_rx_ts_en(ts), .fifo_send_request(req), .fifo_is_tx(istx),
        .fifo_reset_pulse(rp), .fifo_abort_req(ap), .fifo_advance(vp)
    );
    task automatic report_and_stop;
        if (n_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdr(input logic [11:0] a);
        h.xfer({txqfc_pkg::CMD_READ, a, 32'h0}, rd);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        rdr(a);
        chk(rd, e);
    endtask
    task automatic wrr(input logic [11:0] a, input logic [31:0] d);
        h.xfer({txqfc_pkg::CMD_WRITE, a, d}, w);
    endtask
    task automatic ev(ref logic s);
        s = 1'h1;
        h.tick(1);
        s = 1'h0;
    endtask
    function automatic int fm(int i);
        return i == 7 ? 31 : 1 + 4 * i;
    endfunction
    function automatic logic [11:0] fa(int m);
        return txqfc_pkg::FCON_BASE + txqfc_pkg::FCON_STRIDE * 12'(m);
    endfunction
    function automatic logic [31:0] stat();
        return {19'h0, tl[4:0], flg[2:0], exf[0], 1'h0, cnt == 0, 1'h0, cnt < 4};
    endfunction
    // one-cycle pulses are counted on the falling edge, where they are settled
    always @(negedge ref_clk)
    begin
        nr += $countones(rp);
        na += $countones(ap);
        nv += $countones(vp);
        nl += (oe === 1'h0);
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            report_and_stop;
        end
    end
    initial
    begin
        void'($urandom(16));
        {cfg, gen, push, sreq, mend, ab, arb, berr, ex, qrst} = 10'h200;
        {sent, sel, dep} = 41'h3;
        pl = 3'($urandom);
        base = $urandom;
        h.tick(2);
        nrst = 1'h1;
        h.tick(4);
        rdc(txqfc_pkg::TXQ_STA_ADDR, 32'h5);
        for (int i = 0; i < 8; i++)
        begin
            wv[i] = {i[2:0], 5'($urandom), 1'h0, i[1:0], 5'($urandom), 9'h1, 7'($urandom)};
            gen = i[2];
            sel = 5'(fm(i));
            rdc(fa(fm(i)), 32'h0060_0400);
            wrr(fa(fm(i)), wv[i]);
            rdc(fa(fm(i)), wv[i] | 32'h400);
            chk(32'(pbytes), bytes[i]);
            chk(32'(depth), 32'(wv[i][28:24]) + 1);
            chk(32'(retry), (gen && !i[1]) ? i[1:0] : 2);
            chk(32'(prio), 32'(wv[i][20:16]));
            chk(32'({rr, ts}), 32'(wv[i][6:5]));
        end
        cfg = 1'h0;
        // clear bits must drop before the fifos are touched again
        h.tick(4);
        for (int i = 0; i < 8; i++)
            rdc(fa(fm(i)), wv[i]);
        v = ~wv[0] & 32'hFF7F_00FF;
        wrr(fa(1), v);
        rdc(fa(1), wv[0] & 32'hFF00_00A0 | v & 32'h007F_005F);
        wrr(fa(1), rd | 32'h200);
        chk(32'(req[0]), 1);
        sent = 31'h1;
        h.tick(1);
        sent = 31'h0;
        h.tick(2);
        chk(32'(req[0]), 0);
        chk(32'(istx), 32'h4111_1111);
        wrr(fa(2), 32'h200);
        chk(32'(req), 0);
        wrr(fa(1), rd | 32'h200);
        chk(32'(req[0]), 1);
        wrr(fa(1), rd | 32'h100);
        chk(32'(req[0]), 0);
        wrr(fa(1), rd | 32'h400);
        // head address reads happen outside configuration mode only
        for (int k = 0; k < 8; k++)
        begin
            {ab, arb, berr} = 3'($urandom);
            if (k < 4)
                ev(push);
            else
                ev(mend);
            hd = (hd + (k < 4)) % 4;
            tl = (tl + (k > 3)) % 4;
            cnt = k < 4 ? cnt + 1 : cnt - 1;
            flg = k > 3 ? {ab, arb, berr} : flg;
            rdc(txqfc_pkg::TXQ_STA_ADDR, stat());
            rdc(txqfc_pkg::TXQ_HEAD_ADDR, base + hd * (8 + bytes[pl]));
        end
        ev(ex);
        exf = 1;
        rdc(txqfc_pkg::TXQ_STA_ADDR, stat());
        wrr(txqfc_pkg::TXQ_STA_ADDR, 32'h0);
        {flg, exf} = 0;
        rdc(txqfc_pkg::TXQ_STA_ADDR, stat());
        {ab, arb, berr} = 3'h7;
        ev(push);
        ev(mend);
        rdr(txqfc_pkg::TXQ_STA_ADDR);
        chk(rd & 32'hF0, 32'hE0);
        ev(sreq);
        rdr(txqfc_pkg::TXQ_STA_ADDR);
        chk(rd & 32'hF0, 32'h0);
        ev(push);
        ev(mend);
        ev(qrst);
        rdr(txqfc_pkg::TXQ_STA_ADDR);
        chk(rd & 32'hF0, 32'h0);
        chk(nr, 32);
        chk(na, 1);
        chk(nv, 1);
        // output enable follows each 388-cycle chip-select window, then idles high
        chk(32'(oe), 1);
        chk(nl % 388, 0);
        chk(32'(nl > 0), 1);
        report_and_stop;
    end
endmodule
`default_nettype wire
